// [rtl/paec_pkg.sv]
package paec_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_INDICATOR = 5'h10;
    localparam logic [15:0] EXPANSION_RESET = 16'h0000;
    localparam logic [15:0] INDICATOR_RESET = 16'h0000;
    // expansion fields
    localparam int EXP_PD_FAULT  = 4;
    localparam int EXP_LP_NP     = 3;
    localparam int EXP_PAGE_RX   = 1;
    localparam int EXP_LP_AN     = 0;
    // indicator config fields
    localparam int CFG_USER_LO   = 12;
    localparam int CFG_TUNE      = 8;
    localparam int CFG_THIRD_LO  = 6;
    localparam int CFG_SECOND_LO = 4;
    localparam int CFG_FIRST_LO  = 2;
    localparam int CFG_ALGO      = 1;
    // ------------------------------------------------------------
    // indicator sources and link timing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_TX, SRC_RX, SRC_LINK, SRC_HALF, SRC_FAST, SRC_COL
    } paec_src_t;
    localparam int CLK_MHZ        = 200;
    localparam int IDLE_WINDOW_US = 1000;
    localparam int IDLE_WINDOW_CYC = IDLE_WINDOW_US * CLK_MHZ;
    localparam int IDLE_RUN       = 12;
    localparam int ERR_LIMIT      = 64;
    localparam int ERR_BLOCK      = 1024;
endpackage

// [rtl/paec_status_if.sv]
`timescale 1ns/1ps
interface paec_status_if;
    logic tx_act;
    logic rx_act;
    logic link;
    logic half;
    logic fast;
    logic col;
    modport src (output tx_act, rx_act, link, half, fast, col);
    modport dst (input  tx_act, rx_act, link, half, fast, col);
endinterface

// [rtl/paec_indicator_mux.sv]
`timescale 1ns/1ps
module paec_indicator_mux
    import paec_pkg::*;
(
    paec_status_if.dst  st,
    input  wire logic [1:0] sel_i,
    input  wire logic [1:0] which_i,
    output logic            led_o
);
    // ------------------------------------------------------------
    // source select per indicator
    // ------------------------------------------------------------
    function automatic logic pick(paec_src_t s, logic t, logic r, logic l,
                                  logic h, logic f, logic c);
        unique case (s)
            SRC_TX:   pick = t;
            SRC_RX:   pick = r;
            SRC_LINK: pick = l;
            SRC_HALF: pick = h;
            SRC_FAST: pick = f;
            default:  pick = c;
        endcase
    endfunction
    paec_src_t src;
    always_comb begin
        unique case (which_i)
            2'h0:    src = paec_src_t'(3'(sel_i));
            2'h1:    src = paec_src_t'(3'(sel_i) + 3'h1);
            default: src = paec_src_t'(3'(sel_i) + 3'h2);
        endcase
        led_o = pick(src, st.tx_act, st.rx_act, st.link, st.half,
                     st.fast, st.col);
    end
endmodule

// [rtl/paec_regs.sv]
`timescale 1ns/1ps
module paec_regs
    import paec_pkg::*;
#(
    parameter int WINDOW_CYC = IDLE_WINDOW_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    output logic      [15:0] reg_rdata_o,
    input  wire logic        pd_fault_i,
    input  wire logic        lp_np_able_i,
    input  wire logic        code_word_valid_i,
    input  wire logic [15:0] code_word_i,
    input  wire logic        lp_an_able_i,
    input  wire logic        sym_valid_i,
    input  wire logic        sym_idle_i,
    input  wire logic        sym_err_i,
    input  wire logic        signal_ok_i,
    input  wire logic        tx_act_i,
    input  wire logic        rx_act_i,
    input  wire logic        half_i,
    input  wire logic        fast_i,
    input  wire logic        col_i,
    output logic             link_o,
    output logic             tx_fast_rise_o,
    output logic [2:0]       indicator_o
);
    if (WINDOW_CYC < 2) begin : g_bad_window
        $error("window too short");
    end
    localparam int WW = $clog2(WINDOW_CYC + 1);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  sync_a;
        logic [1:0]  sync_b;
        logic [1:0]  sync_c;
        logic        pd_lh;
        logic        page_lh;
        logic [15:0] last_word;
        logic [1:0]  match_cnt;
        logic        page_cond;
        logic [15:0] cfg;
        logic [WW-1:0] win_cnt;
        logic [3:0]  idle_cnt;
        logic        idle_ok;
        logic [9:0]  sym_cnt;
        logic [6:0]  err_cnt;
        logic        link;
        logic [15:0] rdata;
        logic [2:0]  leds;
    } paec_state_t;
    paec_state_t q, d;
    paec_status_if st ();
    logic [2:0] led_raw;
    assign st.tx_act = tx_act_i;
    assign st.rx_act = rx_act_i;
    assign st.link   = q.link;
    assign st.half   = half_i;
    assign st.fast   = fast_i;
    assign st.col    = col_i;
    for (genvar g = 0; g < 3; g++) begin : g_led
        paec_indicator_mux u_mux (
            .st      (st),
            .sel_i   (q.cfg[CFG_FIRST_LO + 2*g +: 2]),
            .which_i (2'(g)),
            .led_o   (led_raw[g])
        );
    end
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // pins pass two flops before use
        d.sync_a = {q.sync_a[0], pd_fault_i};
        d.sync_b = {q.sync_b[0], lp_np_able_i};
        d.sync_c = {q.sync_c[0], lp_an_able_i};
        // code word run detection
        if (code_word_valid_i) begin
            d.last_word = code_word_i;
            if (code_word_i == q.last_word && q.match_cnt != 2'h0) begin
                if (q.match_cnt != 2'h2)
                    d.match_cnt = q.match_cnt + 2'h1;
            end else begin
                d.match_cnt = 2'h1;
            end
        end
        // third identical word: two matches already counted
        d.page_cond = (q.match_cnt == 2'h2) && code_word_valid_i
                      && code_word_i == q.last_word;
        // latched-high: hold until read, set wins
        if (reg_rd_i && reg_addr_i == ADDR_EXPANSION) begin
            d.pd_lh   = 1'b0;
            d.page_lh = 1'b0;
        end
        if (q.sync_a[1]) d.pd_lh = 1'b1;
        if (d.page_cond) d.page_lh = 1'b1;
        // config writes
        if (reg_wr_i && reg_addr_i == ADDR_INDICATOR) begin
            d.cfg = reg_wdata_i & 16'hF1FE;
        end
        // link monitor
        if (!signal_ok_i) begin
            d.link = 1'b0;
        end else if (q.cfg[CFG_ALGO]) begin
            d.win_cnt = q.win_cnt + WW'(1);
            if (sym_valid_i) begin
                d.idle_cnt = sym_idle_i ? ((q.idle_cnt == 4'(IDLE_RUN))
                             ? q.idle_cnt : q.idle_cnt + 4'h1) : 4'h0;
                if (d.idle_cnt == 4'(IDLE_RUN)) d.idle_ok = 1'b1;
            end
            if (q.win_cnt == WW'(WINDOW_CYC - 1)) begin
                d.link    = q.idle_ok;
                d.win_cnt = '0;
                d.idle_ok = 1'b0;
            end
        end else if (sym_valid_i) begin
            d.sym_cnt = q.sym_cnt + 10'h1;
            if (sym_err_i && q.err_cnt <= 7'(ERR_LIMIT))
                d.err_cnt = q.err_cnt + 7'h1;
            if (d.err_cnt > 7'(ERR_LIMIT)) d.link = 1'b0;
            if (q.sym_cnt == 10'(ERR_BLOCK - 1)) begin
                d.link    = d.err_cnt <= 7'(ERR_LIMIT);
                d.err_cnt = '0;
            end
        end
        // read data
        d.rdata = 16'h0000;
        if (reg_addr_i == ADDR_EXPANSION) begin
            d.rdata[EXP_PD_FAULT] = q.pd_lh;
            d.rdata[EXP_LP_NP]    = q.sync_b[1];
            d.rdata[EXP_PAGE_RX]  = q.page_lh;
            d.rdata[EXP_LP_AN]    = q.sync_c[1];
        end else if (reg_addr_i == ADDR_INDICATOR) begin
            d.rdata = q.cfg;
        end
        d.leds = led_raw;
    end
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            q       <= '0;
            q.cfg   <= INDICATOR_RESET;
            q.rdata <= EXPANSION_RESET;
        end else if (ce_i) begin
            q <= d;
        end
    end
    assign reg_rdata_o    = q.rdata;
    assign link_o         = q.link;
    assign tx_fast_rise_o = q.cfg[CFG_TUNE];
    assign indicator_o    = q.leds;
endmodule

// [testbench/paec_regs_props.sv]
`timescale 1ns/1ps
module paec_regs_props
    import paec_pkg::*;
#(
    parameter int WINDOW_CYC = 50
) (
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    input  wire logic        ce_i,
    input  wire logic [4:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic [15:0] reg_rdata_o,
    input  wire logic        signal_ok_i,
    input  wire logic        link_o,
    input  wire logic        tx_fast_rise_o,
    input  wire logic [2:0]  indicator_o
);
    // ------------------------------------------------------------
    // port checks
    // ------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    reset_outputs_a: assert property ($rose(rstn_i) |-> !link_o &&
        !tx_fast_rise_o && indicator_o == 3'h0 && reg_rdata_o == 16'h0000)
        else $error("outputs not clear after reset");
    tune_follows_a: assert property (ce_i && reg_wr_i &&
        reg_addr_i == ADDR_INDICATOR ##1 !reg_wr_i ##1 1'b1 |->
        tx_fast_rise_o == $past(reg_wdata_i[CFG_TUNE], 2))
        else $error("tuning output does not follow written bit");
    exp_reserved_a: assert property (ce_i &&
        reg_addr_i == ADDR_EXPANSION |=>
        reg_rdata_o[15:5] == 11'h000 && !reg_rdata_o[2])
        else $error("reserved expansion bits not zero");
    cfg_reserved_a: assert property (ce_i &&
        reg_addr_i == ADDR_INDICATOR |=>
        reg_rdata_o[11:9] == 3'h0 && !reg_rdata_o[0])
        else $error("reserved config bits not zero");
    unmapped_zero_a: assert property (ce_i &&
        reg_addr_i != ADDR_EXPANSION && reg_addr_i != ADDR_INDICATOR
        |=> reg_rdata_o == 16'h0000)
        else $error("unmapped address reads nonzero");
    pd_hold_a: assert property (ce_i && reg_addr_i == ADDR_EXPANSION &&
        !reg_rd_i ##1 ce_i && reg_addr_i == ADDR_EXPANSION && !reg_rd_i &&
        reg_rdata_o[EXP_PD_FAULT] |=> reg_rdata_o[EXP_PD_FAULT])
        else $error("fault bit dropped without a read");
    page_hold_a: assert property (ce_i && reg_addr_i == ADDR_EXPANSION &&
        !reg_rd_i ##1 ce_i && reg_addr_i == ADDR_EXPANSION && !reg_rd_i &&
        reg_rdata_o[EXP_PAGE_RX] |=> reg_rdata_o[EXP_PAGE_RX])
        else $error("page bit dropped without a read");
    link_drop_a: assert property (!signal_ok_i [*4] |=> !link_o)
        else $error("link up without signal");
endmodule

// [testbench/paec_regs_tb.sv]
`timescale 1ns/1ps
module paec_regs_tb;
    import paec_pkg::*;
`define CHK(nm, e, s) \
    begin \
        total_checks++; \
        if ((s) !== (e)) begin \
            n_mismatch++; \
            $display("ERROR %s expected %h seen %h", nm, e, s); \
        end \
    end
    localparam int WIN = 50;
    logic        clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        pd_fault_i = 1'b0, lp_np_able_i = 1'b0, lp_an_able_i = 1'b0;
    logic        code_word_valid_i = 1'b0, sym_valid_i = 1'b0;
    logic        sym_idle_i = 1'b0, sym_err_i = 1'b0, signal_ok_i = 1'b0;
    logic        link_o, tx_fast_rise_o;
    logic [2:0]  indicator_o;
    logic [4:0]  reg_addr_i = 5'h00;
    logic [5:0]  st = 6'h00;
    logic [15:0] reg_wdata_i = 16'h0000, code_word_i = 16'h0000;
    logic [15:0] reg_rdata_o, rd_v, w_v;
    int          n_mismatch = 0, total_checks = 0, cyc = 0;
    paec_regs #(.WINDOW_CYC(WIN)) i_dut (
        .clk_i, .rstn_i, .ce_i(1'b1), .reg_addr_i, .reg_wr_i, .reg_rd_i,
        .reg_wdata_i, .reg_rdata_o, .pd_fault_i, .lp_np_able_i,
        .code_word_valid_i, .code_word_i, .lp_an_able_i, .sym_valid_i,
        .sym_idle_i, .sym_err_i, .signal_ok_i, .tx_act_i(st[0]),
        .rx_act_i(st[1]), .half_i(st[3]), .fast_i(st[4]), .col_i(st[5]),
        .link_o, .tx_fast_rise_o, .indicator_o);
    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(negedge clk_i);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge clk_i);
        d = reg_rdata_o;
        reg_rd_i = 1'b0;
    endtask
    task automatic cw(input logic [15:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            code_word_valid_i = 1'b1;
            code_word_i = w;
        end
        @(negedge clk_i);
        code_word_valid_i = 1'b0;
    endtask
    task automatic syms(input int n, input int errs, input logic idle);
        for (int i = 0; i < n; i++) begin
            @(negedge clk_i);
            sym_valid_i = 1'b1;
            sym_err_i = (i < errs);
            sym_idle_i = idle;
        end
        @(negedge clk_i);
        sym_valid_i = 1'b0;
        repeat (4) @(negedge clk_i);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(91));
        repeat (16) @(negedge clk_i);
        rstn_i = 1'b1;
        rd(ADDR_EXPANSION, rd_v);
        `CHK("expansion", EXPANSION_RESET, rd_v)
        rd(ADDR_INDICATOR, rd_v);
        `CHK("config", INDICATOR_RESET, rd_v)
        for (int i = 0; i < 8; i++) begin
            w_v = (i == 0) ? 16'hFFFF : 16'($urandom);
            wr(ADDR_INDICATOR, w_v);
            rd(ADDR_INDICATOR, rd_v);
            `CHK("config", w_v & 16'hF1FE, rd_v)
            `CHK("tune", w_v[CFG_TUNE], tx_fast_rise_o)
        end
        rd(5'h1F, rd_v);
        `CHK("unmapped", 16'h0000, rd_v)
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_INDICATOR, 16'((k << 6) | (k << 4) | (k << 2)));
            repeat (4) begin
                st = 6'($urandom) & 6'h3B;
                repeat (4) @(negedge clk_i);
                `CHK("indicator", {st[k+2], st[k+1], st[k]}, indicator_o)
            end
        end
        pd_fault_i = 1'b1;
        lp_np_able_i = 1'b1;
        lp_an_able_i = 1'b1;
        repeat (4) @(negedge clk_i);
        pd_fault_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rd(ADDR_EXPANSION, rd_v);
        `CHK("expansion", 16'h0019, rd_v)
        wr(ADDR_EXPANSION, 16'hFFFF);
        rd(ADDR_EXPANSION, rd_v);
        `CHK("expansion", 16'h0009, rd_v)
        lp_np_able_i = 1'b0;
        lp_an_able_i = 1'b0;
        cw(16'hA5C3, 2);
        cw(16'h5A3C, 1);
        rd(ADDR_EXPANSION, rd_v);
        `CHK("page", 16'h0000, rd_v)
        cw(16'h5A3C, 2);
        rd(ADDR_EXPANSION, rd_v);
        `CHK("page", 16'h0002, rd_v)
        wr(ADDR_INDICATOR, 16'h0000);
        signal_ok_i = 1'b1;
        syms(ERR_BLOCK, 0, 1'b0);
        `CHK("link", 1'b1, link_o)
        syms(ERR_BLOCK, ERR_LIMIT + 1, 1'b0);
        `CHK("link", 1'b0, link_o)
        wr(ADDR_INDICATOR, 16'h0002);
        syms(3 * WIN, 0, 1'b1);
        `CHK("link", 1'b1, link_o)
        syms(3 * WIN, 0, 1'b0);
        `CHK("link", 1'b0, link_o)
        complete_run();
    end
endmodule
bind paec_regs paec_regs_props #(.WINDOW_CYC(WINDOW_CYC)) i_props (
    .clk_i, .rstn_i, .ce_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
    .reg_wdata_i, .reg_rdata_o, .signal_ok_i, .link_o,
    .tx_fast_rise_o, .indicator_o);
